//--- hdl/brss_pkg.sv
// constants and types for the boot, reset and shutdown sequencer
package brss_pkg;
   localparam int CLK_HZ = 100_000_000;
   localparam int OSC_SLOW_HZ = 20_000;
   localparam int OSC_FAST_HZ = 12_000_000;
   localparam int RESET_DELAY_MS = 50;
   localparam int SLOW_DIV_CYCLES = CLK_HZ / OSC_SLOW_HZ;
   localparam int RESET_DELAY_TICKS = RESET_DELAY_MS * OSC_SLOW_HZ / 1000;
   localparam int EEPROM_IMAGE_BYTES = 32768;
   localparam int NUM_CORES = 8;
   localparam int NUM_PINS = 32;
   localparam int HUB_PERIOD = 16;
   localparam int HUB_SLOT = HUB_PERIOD / NUM_CORES;
   localparam int PIN_SCL = 28;
   localparam int PIN_SDA = 29;
   localparam int PIN_TX = 30;
   localparam int PIN_RX = 31;
   localparam logic [7:0] CORE0_ONLY = 8'h01;

   typedef enum logic [2:0] {
      S_SHUT, S_DELAY, S_HOST, S_HXFER, S_EE, S_EELOAD, S_RUN
   } brss_state_t;

   typedef enum logic {IMG_LOADER, IMG_INTERP} brss_img_t;

   // status and pin requests from the boot loader running on core 0
   typedef struct packed {
      logic done;
      logic found;
      logic suspend;
      logic byte_stb;
      logic tx;
      logic scl_low;
      logic sda_low;
   } brss_ldr_t;

   typedef struct packed {
      logic [7:0] enable;
      brss_img_t image;
   } brss_core_t;

   typedef struct packed {
      logic [31:0] oe;
      logic [31:0] out;
   } brss_pins_t;
endpackage : brss_pkg

//--- hdl/brss_top.sv
// boot, reset and shutdown sequencer with hub round-robin
// Operation
// - reset pin low: cores off, pins floating
// - restart begins 50 ms after reset rises
// - strap low makes reset pin weak output
// - oscillator slow first, fast after delay
// - only core zero starts, running loader
// - loader first probes host serial bits
// - host identifies and downloads the program
// - no host: probe EEPROM, copy 32 KB
// - nothing found: stop core, shut down
// - load ok, no suspend: run interpreter
// - bits 28-31 boot use, then general
// - after boot application controls clock, pins, cores
// - shutdown stops clock, all pins input
// - brownout, reset low or restart cause shutdown
// - leave shutdown: supply good, reset high
// - pins and counter readable by all
// - hub round-robin, one slot per 16
`timescale 1ns/1ns
module brss_top #(
   parameter int SLOW_DIV_CYCLES = brss_pkg::SLOW_DIV_CYCLES
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // reset pin and straps
   input wire logic chip_reset_low_pin_in,
   output logic chip_reset_low_pin_out,
   output logic chip_reset_low_pin_oe,
   output logic chip_reset_low_pin_weak,
   input wire logic brownout_detect_enable_low,
   input wire logic supply_below_threshold,
   // oscillator
   output logic osc_fast_sel,
   output logic sys_clock_run,
   // cores and boot loader
   output brss_pkg::brss_core_t core_ctl,
   input wire brss_pkg::brss_ldr_t loader,
   // application controls
   input wire logic app_restart_req,
   input wire logic app_fast_sel,
   input wire logic [7:0] app_core_enable,
   input wire brss_pkg::brss_pins_t app_pins,
   // i/o pins
   input wire logic [31:0] port_in,
   output brss_pkg::brss_pins_t port_drive,
   // shared resources
   output logic [31:0] io_in_shared,
   output logic [31:0] sys_counter,
   output logic [7:0] hub_grant
);
   localparam int DIVW = $clog2(SLOW_DIV_CYCLES + 1);
   localparam logic [DIVW-1:0] DIV_LAST = DIVW'(SLOW_DIV_CYCLES - 1);
   localparam logic [9:0] DLY_LAST = 10'(brss_pkg::RESET_DELAY_TICKS - 1);
   localparam logic [14:0] EE_LAST = 15'(brss_pkg::EEPROM_IMAGE_BYTES - 1);

   brss_pkg::brss_state_t state;
   brss_pkg::brss_state_t next_state;
   logic [34:0] sync_meta;
   logic [34:0] sync_q;
   logic res_low;
   logic bo_raw;
   logic strap_raw;
   logic [1:0] cap_cnt;
   logic strap_low;
   logic bo_trip;
   logic trig;
   logic fail_hold;
   logic [DIVW-1:0] div_cnt;
   logic tick;
   logic [9:0] dly_cnt;
   logic [14:0] ee_cnt;
   logic half;
   logic [2:0] hub_idx;
   logic clk_on;
   logic host_grp;
   logic ee_grp;

   // two-flop synchroniser for pins, reset pin, strap and brownout
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sync_meta <= 35'h0;
         sync_q <= 35'h0;
      end
      else
      begin
         sync_meta <= {port_in, chip_reset_low_pin_in, brownout_detect_enable_low,
                       supply_below_threshold};
         sync_q <= sync_meta;
      end
   end
   assign res_low = !sync_q[2];
   assign strap_raw = sync_q[1];
   assign bo_raw = sync_q[0];

   // strap caught once, after the synchroniser has filled
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cap_cnt <= 2'h0;
         strap_low <= 1'b0;
      end
      else if (cap_cnt != 2'h3)
      begin
         cap_cnt <= cap_cnt + 2'h1;
         if (cap_cnt == 2'h2)
            strap_low <= !strap_raw;
      end
   end

   assign bo_trip = strap_low && bo_raw;
   assign trig = res_low || bo_trip || (state == brss_pkg::S_RUN && app_restart_req);

   // reset pin: weak monitor output when brownout detection is on
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         chip_reset_low_pin_oe <= 1'b0;
         chip_reset_low_pin_weak <= 1'b0;
         chip_reset_low_pin_out <= 1'b0;
      end
      else
      begin
         chip_reset_low_pin_oe <= strap_low;
         chip_reset_low_pin_weak <= strap_low;
         chip_reset_low_pin_out <= !bo_trip;
      end
   end

   // slow oscillator tick and reset delay
   assign tick = (state == brss_pkg::S_DELAY) && (div_cnt == DIV_LAST);
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         div_cnt <= '0;
         dly_cnt <= 10'h0;
      end
      else if (state != brss_pkg::S_DELAY)
      begin
         div_cnt <= '0;
         dly_cnt <= 10'h0;
      end
      else
      begin
         div_cnt <= tick ? '0 : div_cnt + 1'b1;
         if (tick)
            dly_cnt <= dly_cnt + 10'h1;
      end
   end

   // image byte counter during eeprom copy
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         ee_cnt <= 15'h0;
      else if (state != brss_pkg::S_EELOAD)
         ee_cnt <= 15'h0;
      else if (loader.byte_stb)
         ee_cnt <= ee_cnt + 15'h1;
   end

   // boot failure or suspend holds shutdown until reset pin pulses
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         fail_hold <= 1'b0;
      else if (next_state == brss_pkg::S_SHUT && !trig)
         fail_hold <= 1'b1;
      else if (res_low)
         fail_hold <= 1'b0;
   end

   // sequencer
   always_comb
   begin
      next_state = state;
      case (state)
         brss_pkg::S_SHUT:
            if (!res_low && !bo_trip && !fail_hold)
               next_state = brss_pkg::S_DELAY;
         brss_pkg::S_DELAY:
            if (tick && dly_cnt == DLY_LAST)
               next_state = brss_pkg::S_HOST;
         brss_pkg::S_HOST:
            if (loader.done)
               next_state = loader.found ? brss_pkg::S_HXFER : brss_pkg::S_EE;
         brss_pkg::S_HXFER:
            if (loader.done)
               next_state = loader.suspend ? brss_pkg::S_SHUT : brss_pkg::S_RUN;
         brss_pkg::S_EE:
            if (loader.done)
               next_state = loader.found ? brss_pkg::S_EELOAD : brss_pkg::S_SHUT;
         brss_pkg::S_EELOAD:
            if (loader.byte_stb && ee_cnt == EE_LAST)
               next_state = brss_pkg::S_RUN;
         brss_pkg::S_RUN:
            next_state = brss_pkg::S_RUN;
         default:
            next_state = brss_pkg::S_SHUT;
      endcase
      if (trig)
         next_state = brss_pkg::S_SHUT;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         state <= brss_pkg::S_SHUT;
      else
         state <= next_state;
   end

   assign clk_on = next_state != brss_pkg::S_SHUT;
   assign host_grp = next_state inside {brss_pkg::S_HOST, brss_pkg::S_HXFER};
   assign ee_grp = next_state inside {brss_pkg::S_HXFER, brss_pkg::S_EE, brss_pkg::S_EELOAD};

   // oscillator and clock gate
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sys_clock_run <= 1'b0;
         osc_fast_sel <= 1'b0;
      end
      else
      begin
         sys_clock_run <= clk_on;
         if (next_state == brss_pkg::S_RUN)
            osc_fast_sel <= app_fast_sel;
         else
            osc_fast_sel <= clk_on && next_state != brss_pkg::S_DELAY;
      end
   end

   // core enables and core 0 image
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         core_ctl <= '{enable: 8'h0, image: brss_pkg::IMG_LOADER};
      else if (next_state == brss_pkg::S_RUN)
         core_ctl <= '{enable: app_core_enable, image: brss_pkg::IMG_INTERP};
      else if (host_grp || ee_grp)
         core_ctl <= '{enable: brss_pkg::CORE0_ONLY, image: brss_pkg::IMG_LOADER};
      else
         core_ctl <= '{enable: 8'h0, image: brss_pkg::IMG_LOADER};
   end

   // pin drive: boot functions on bits 28-31, application afterwards
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         port_drive <= '0;
      else if (next_state == brss_pkg::S_RUN)
         port_drive <= app_pins;
      else
      begin
         port_drive <= '0;
         if (host_grp)
         begin
            port_drive.oe[brss_pkg::PIN_TX] <= 1'b1;
            port_drive.out[brss_pkg::PIN_TX] <= loader.tx;
         end
         if (ee_grp)
         begin
            port_drive.oe[brss_pkg::PIN_SCL] <= loader.scl_low;
            port_drive.oe[brss_pkg::PIN_SDA] <= loader.sda_low;
         end
      end
   end

   // common resources readable by every core
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         io_in_shared <= 32'h0;
         sys_counter <= 32'h0;
      end
      else
      begin
         io_in_shared <= sync_q[34:3];
         if (clk_on)
            sys_counter <= sys_counter + 32'h1;
      end
   end

   // hub runs at half rate: one two-cycle slot per core
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         half <= 1'b0;
         hub_idx <= 3'h0;
      end
      else if (clk_on)
      begin
         half <= !half;
         if (half)
            hub_idx <= hub_idx + 3'h1;
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < brss_pkg::NUM_CORES; gi++)
      begin : g_grant
         always_ff @(posedge clk or negedge rst_n)
         begin
            if (!rst_n)
               hub_grant[gi] <= 1'b0;
            else
               hub_grant[gi] <= clk_on && hub_idx == 3'(gi);
         end
      end
   endgenerate

   // checks
   int dly_cyc;
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         dly_cyc <= 0;
      else
         dly_cyc <= (state == brss_pkg::S_DELAY) ? dly_cyc + 1 : 0;
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   a_reset_quiet: assert property (res_low |=> core_ctl.enable == 8'h0 && port_drive.oe == 32'h0)
      else $error("reset low but cores or pins active");
   a_delay_length: assert property (state == brss_pkg::S_DELAY && next_state == brss_pkg::S_HOST
      |-> dly_cyc == SLOW_DIV_CYCLES * brss_pkg::RESET_DELAY_TICKS - 1)
      else $error("restart delay wrong length");
   a_strap_weak: assert property (cap_cnt == 2'h3 && $stable(strap_low) && strap_low
      |-> chip_reset_low_pin_oe && chip_reset_low_pin_weak)
      else $error("reset pin not weakly driven with strap low");
   a_slow_in_delay: assert property (state == brss_pkg::S_DELAY |-> !osc_fast_sel ##1
      (state != brss_pkg::S_HOST || osc_fast_sel))
      else $error("oscillator setting wrong around delay");
   a_core0_only: assert property (state inside {brss_pkg::S_HOST, brss_pkg::S_EE}
      |-> core_ctl.enable == 8'h01 && core_ctl.image == brss_pkg::IMG_LOADER)
      else $error("boot must run only core zero");
   a_host_first: assert property ($rose(state == brss_pkg::S_EE)
      |-> $past(state) == brss_pkg::S_HOST && $past(!loader.found))
      else $error("eeprom probed without failed host probe");
   a_fail_shut: assert property (state == brss_pkg::S_EE && loader.done && !loader.found
      |=> state == brss_pkg::S_SHUT ##1 state == brss_pkg::S_SHUT)
      else $error("no boot source but no shutdown");
   a_run_interp: assert property ($rose(state == brss_pkg::S_RUN)
      |-> core_ctl.image == brss_pkg::IMG_INTERP && !$past(loader.suspend))
      else $error("run entered without interpreter");
   a_shut_quiet: assert property (state == brss_pkg::S_SHUT
      |-> !sys_clock_run && port_drive.oe == 32'h0 && hub_grant == 8'h0)
      else $error("shutdown with clock or pins active");
   a_restart_trig: assert property (state == brss_pkg::S_RUN && app_restart_req
      |=> state == brss_pkg::S_SHUT)
      else $error("restart request ignored");
   a_shut_exit: assert property (state == brss_pkg::S_SHUT && (res_low || bo_trip)
      |=> state == brss_pkg::S_SHUT)
      else $error("left shutdown too early");
   a_hub_rotate: assert property ($rose(hub_grant[0])
      |-> ##2 (hub_grant == 8'h02 || !sys_clock_run))
      else $error("hub did not pass to core one");

   c_host_boot: cover property (state == brss_pkg::S_HXFER ##[1:1000] state == brss_pkg::S_RUN);
   c_ee_boot: cover property (state == brss_pkg::S_EELOAD ##1 state == brss_pkg::S_EELOAD);
   c_fail_boot: cover property (state == brss_pkg::S_EE ##1 state == brss_pkg::S_SHUT);
   c_restart: cover property (state == brss_pkg::S_RUN && app_restart_req);
endmodule : brss_top

//--- verif/brss_boot_partner.sv
// boot loader probe model facing the host link and the eeprom
`timescale 1ns/1ns
module brss_boot_partner (
   // clock
   input wire logic clk,
   // scenario controls
   input wire logic host_present,
   input wire logic ee_present,
   input wire logic suspend,
   input wire logic slow,
   // design side
   input wire brss_pkg::brss_core_t core_ctl,
   output brss_pkg::brss_ldr_t loader,
   output logic [16:0] bytes_taken
);
   logic on;
   assign on = core_ctl.enable == 8'h01 && core_ctl.image == brss_pkg::IMG_LOADER;
   // counts image bytes the design has taken during one boot
   always @(posedge clk)
   begin
      if (!on)
         bytes_taken <= 17'h00000;
      else if (loader.byte_stb)
         bytes_taken <= bytes_taken + 17'h00001;
   end
   task automatic probe(input logic fnd, input logic sus);
      repeat (slow ? 40 : 3) @(posedge clk);
      loader.found <= fnd;
      loader.suspend <= sus;
      loader.done <= 1'b1;
      @(posedge clk);
      loader.done <= 1'b0;
   endtask : probe
   // tx idles high; probes only while core zero runs the loader
   initial
   begin
      loader = 7'h04;
      forever
      begin
         @(posedge clk);
         if (on)
         begin
            probe(host_present, 1'b0);
            if (host_present)
               probe(1'b1, suspend);
            else
            begin
               loader.tx <= 1'b0;
               loader.scl_low <= 1'b1;
               probe(ee_present, 1'b0);
               repeat (ee_present ? 32768 : 0)
               begin
                  loader.byte_stb <= 1'b1;
                  loader.sda_low <= 1'b1;
                  @(posedge clk);
               end
            end
            {loader.found, loader.suspend, loader.byte_stb, loader.tx, loader.scl_low,
             loader.sda_low} <= 6'h04;
            while (on)
               @(posedge clk);
         end
      end
   end
endmodule : brss_boot_partner

//--- verif/brss_tb_top.sv
// self-checking bench for the boot, reset and shutdown sequencer
`timescale 1ns/1ns
module brss_tb_top;
   logic clk = 1'b0, rst_n = 1'b0, ext_low = 1'b0, strap = 1'b1, supply_low = 1'b0;
   logic restart_req = 1'b0, hp = 1'b1, ep = 1'b0, sus = 1'b0, slow = 1'b1, app_fast = 1'b0;
   logic [31:0] port_in = 32'h0;
   int err_total = 0, comparisons = 0;
   logic pin_out, pin_oe, pin_weak, pin_in, osc_fast_sel, sys_clock_run;
   logic [31:0] io_in_shared, sys_counter;
   logic [7:0] hub_grant;
   logic [16:0] bytes_taken;
   brss_pkg::brss_core_t core_ctl;
   brss_pkg::brss_ldr_t loader;
   brss_pkg::brss_pins_t port_drive;
   localparam brss_pkg::brss_pins_t APP_PINS = 64'h0000_00ff_0000_0f0f;
   // external low wins over the weak drive; pull-up otherwise
   assign pin_in = ext_low ? 1'b0 : (pin_oe ? pin_out : 1'b1);
   always #5 clk = ~clk;
   brss_top #(.SLOW_DIV_CYCLES(2)) dut (
      .clk(clk), .rst_n(rst_n), .chip_reset_low_pin_in(pin_in),
      .chip_reset_low_pin_out(pin_out), .chip_reset_low_pin_oe(pin_oe),
      .chip_reset_low_pin_weak(pin_weak), .brownout_detect_enable_low(strap),
      .supply_below_threshold(supply_low), .osc_fast_sel(osc_fast_sel),
      .sys_clock_run(sys_clock_run), .core_ctl(core_ctl), .loader(loader),
      .app_restart_req(restart_req), .app_fast_sel(app_fast), .app_core_enable(8'h05),
      .app_pins(APP_PINS), .port_in(port_in), .port_drive(port_drive),
      .io_in_shared(io_in_shared), .sys_counter(sys_counter), .hub_grant(hub_grant)
   );
   brss_boot_partner u_partner (
      .clk(clk), .host_present(hp), .ee_present(ep), .suspend(sus), .slow(slow),
      .core_ctl(core_ctl), .loader(loader), .bytes_taken(bytes_taken)
   );
   task automatic final_report();
      if (err_total == 0 && comparisons > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : final_report
   task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string msg);
      comparisons++;
      if (seen !== exp)
      begin
         err_total++;
         $display("[FAIL] %0t %s", $time, msg);
      end
   endtask : check
   function automatic bit hit(input int sel);
      case (sel)
         0: return osc_fast_sel === 1'b1 && core_ctl.enable === 8'h01;
         1: return core_ctl.image === brss_pkg::IMG_INTERP;
         2: return sys_clock_run === 1'b0;
         3: return hub_grant === 8'h80;
         4: return hub_grant === 8'h01;
         default: return port_drive.oe[30] === 1'b0;
      endcase
   endfunction : hit
   task automatic wait_on(input int sel, input int lim, output int n);
      n = 0;
      while (!hit(sel) && n < lim)
      begin
         @(posedge clk);
         #1;
         n++;
      end
      if (!hit(sel))
      begin
         err_total++;
         $display("[FAIL] %0t wait %0d timed out", $time, sel);
         final_report();
      end
   endtask : wait_on
   task automatic pin_boot();
      int n;
      @(posedge clk);
      ext_low <= 1'b1;
      repeat (4) @(posedge clk);
      #1;
      check({sys_clock_run, core_ctl.enable, port_drive.oe}, 41'h0, "reset held");
      @(posedge clk);
      ext_low <= 1'b0;
      repeat (100) @(posedge clk);
      #1;
      check({osc_fast_sel, sys_clock_run, core_ctl.enable}, 10'h100, "delay phase");
      wait_on(0, 3000, n);
      check(n >= 1900 && n <= 1905, 1'b1, "restart delay");
      check(core_ctl.image, brss_pkg::IMG_LOADER, "loader image");
      check({port_drive.oe[30:28], port_drive.out[30]}, 4'b1001, "host probe");
   endtask : pin_boot
   task automatic host_run();
      int n;
      wait_on(1, 500, n);
      check({core_ctl.enable, osc_fast_sel}, 9'h00a, "app cores, clock");
      check(port_drive, APP_PINS, "app pins");
      @(posedge clk);
      app_fast <= 1'b1;
      @(posedge clk);
      #1;
      check(osc_fast_sel, 1'b1, "app clock speed");
   endtask : host_run
   task automatic shared();
      int n;
      logic [31:0] c;
      wait_on(3, 40, n);
      wait_on(4, 40, n);
      for (int k = 0; k < 16; k++)
      begin
         check(hub_grant, 8'h01 << (k / 2), "hub slot");
         @(posedge clk);
         #1;
      end
      @(posedge clk);
      port_in <= 32'ha5c3_0f96;
      supply_low <= 1'b1;
      repeat (4) @(posedge clk);
      #1;
      check(io_in_shared, 32'ha5c3_0f96, "shared pins");
      check(sys_clock_run, 1'b1, "strap high ignores supply");
      c = sys_counter;
      @(posedge clk);
      supply_low <= 1'b0;
      #1;
      check(sys_counter, c + 32'h1, "system counter");
   endtask : shared
   task automatic restart(input logic h, input logic e);
      int n;
      @(posedge clk);
      hp <= h;
      ep <= e;
      restart_req <= 1'b1;
      @(posedge clk);
      restart_req <= 1'b0;
      #1;
      wait_on(2, 4, n);
      check(port_drive.oe, 32'h0, "pins in shutdown");
      wait_on(0, 2100, n);
      @(posedge clk);
      restart_req <= 1'b1;
      @(posedge clk);
      restart_req <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
      check(sys_clock_run, 1'b1, "restart outside run");
   endtask : restart
   task automatic ee_load();
      int n;
      wait_on(5, 200, n);
      repeat (3) @(posedge clk);
      #1;
      check({port_drive.oe[29:28], port_drive.out[28]}, 3'b010, "eeprom pins");
      repeat (60) @(posedge clk);
      #1;
      check(port_drive.oe[29], 1'b1, "eeprom data drive");
      wait_on(1, 40000, n);
      check(bytes_taken, 17'h08000, "image length");
   endtask : ee_load
   task automatic fail_hold();
      int n;
      wait_on(2, 200, n);
      check({core_ctl.enable, port_drive.oe}, 40'h0, "boot failed");
      repeat (2500) @(posedge clk);
      #1;
      check(sys_clock_run, 1'b0, "held in shutdown");
   endtask : fail_hold
   task automatic suspend_stop();
      int n;
      @(posedge clk);
      hp <= 1'b1;
      sus <= 1'b1;
      slow <= 1'b0;
      pin_boot();
      wait_on(2, 100, n);
      check(core_ctl.enable, 8'h00, "suspended");
   endtask : suspend_stop
   task automatic brownout();
      int n;
      @(posedge clk);
      rst_n <= 1'b0;
      strap <= 1'b0;
      sus <= 1'b0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      repeat (50) @(posedge clk);
      #1;
      check({pin_oe, pin_weak, pin_out, sys_clock_run}, 4'hf, "monitor drive");
      @(posedge clk);
      supply_low <= 1'b1;
      wait_on(2, 8, n);
      check(pin_out, 1'b0, "monitor shows trip");
      @(posedge clk);
      supply_low <= 1'b0;
      wait_on(0, 2100, n);
   endtask : brownout
   initial
   begin
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      #1;
      check(pin_oe, 1'b0, "strap high");
      pin_boot();
      host_run();
      shared();
      restart(1'b0, 1'b1);
      ee_load();
      restart(1'b0, 1'b0);
      fail_hold();
      suspend_stop();
      brownout();
      final_report();
   end
endmodule : brss_tb_top
